// ### ipx_irq_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - base priority top bits read ones
// - base priority bits pick low or high
// - extended enable top bits read zeros
// - enable bit 5 gates comparator rising
// - enable bit 4 gates comparator falling
// - enable bit 3 gates counter array
// - enable bit 2 gates conversion complete
// - enable bit 1 gates window compare
// - enable bit 0 gates two-wire serial
// - extended priority bits pick low/high
// - extended priority top bits read ones
// - config bit 7 is ext1 polarity
// - config bits 6-4 pick ext1 pin
// - external inputs only sample, never drive
// - skipped pins get no crossbar peripheral
// - config bit 3 is ext0 polarity
// - config bits 2-0 pick ext0 pin
// - edge pending clears on vector; level follows
// - high preempts low; fixed order ties
// - global gate overrides all masks
module ipx_irq_ctrl (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // special function register bus
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_prio_bank_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  // base enable register and external modes, kept outside
  input  wire logic        global_irq_gate_in,
  input  wire logic [5:0]  base_enable_in,
  input  wire logic [1:0]  ext_edge_mode_in,
  // peripheral pending flags
  input  wire logic [9:0]  periph_flag_in,
  // port 0 pins and crossbar
  input  wire logic [7:0]  port0_pin_in,
  input  wire logic [7:0]  crossbar_skip_reg_in,
  input  wire logic [7:0]  periph_route_in,
  output logic      [7:0]  periph_route_out,
  // core side
  input  wire logic        vector_ack_in,
  input  wire logic        reti_in,
  output logic      [11:0] irq_req_out,
  output logic      [11:0] irq_level_out,
  output logic      [1:0]  ext_pending_out,
  output logic             irq_valid_out,
  output logic      [3:0]  irq_source_out,
  output logic             irq_high_out
);

  typedef struct packed {
    logic [5:0]  base_priority_select;
    logic [5:0]  extended_irq_enable;
    logic [5:0]  extended_irq_priority;
    logic [7:0]  ext_pin_irq_config;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic [1:0]  ext_active_prev;
    logic [1:0]  ext_edge_pending;
    logic        in_service_high;
    logic        in_service_low;
    logic [11:0] req;
    logic [11:0] level;
    logic [1:0]  ext_pending;
    logic        valid;
    logic [3:0]  source;
    logic        high;
    logic [7:0]  rdata;
    logic [7:0]  route;
  } ipx_state_type;

  ipx_state_type st;
  ipx_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // pin mux, used by both external inputs
  function automatic logic ipx_pick_pin(input logic [7:0] pins, input logic [2:0] sel);
    ipx_pick_pin = pins[sel];
  endfunction

  // lowest set index wins the fixed order
  function automatic logic [3:0] ipx_first(input logic [11:0] mask);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = ipx_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 4'(i);
      end
    end
    ipx_first = idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic [1:0]  ext_active;
  logic [1:0]  ext_sel_pin;
  logic [1:0]  ext_polarity;
  logic [1:0]  ext_clear;
  logic [1:0]  ext_flag;
  logic [11:0] pending;
  logic [11:0] enable;
  logic [11:0] hi_mask;
  logic [11:0] lo_mask;
  logic        wr_base;
  logic        wr_cfg;
  logic        wr_eie;
  logic        wr_eip;

  always_comb begin
    next_st = st;

    // a write to the shared offset goes to priority or enable by bank
    wr_base = sfr_wr_in && (sfr_addr_in == ipx_pkg::BASE_PRIORITY_ADDR);
    wr_cfg  = sfr_wr_in && (sfr_addr_in == ipx_pkg::EXT_PIN_CFG_ADDR);
    wr_eie  = sfr_wr_in && (sfr_addr_in == ipx_pkg::EXT_ENABLE_ADDR) && !sfr_prio_bank_in;
    wr_eip  = sfr_wr_in && (sfr_addr_in == ipx_pkg::EXT_PRIORITY_ADDR) && sfr_prio_bank_in;

    // upper bits are not stored, so writes to them vanish
    if (wr_base) begin
      next_st.base_priority_select = sfr_wdata_in[5:0];
    end
    if (wr_eie) begin
      next_st.extended_irq_enable = sfr_wdata_in[5:0];
    end
    if (wr_eip) begin
      next_st.extended_irq_priority = sfr_wdata_in[5:0];
    end
    if (wr_cfg) begin
      next_st.ext_pin_irq_config = sfr_wdata_in;
    end

    // read data lands one cycle after the strobe
    next_st.rdata = ipx_pkg::UNMAPPED_READ;
    if (sfr_rd_in) begin
      if (sfr_addr_in == ipx_pkg::BASE_PRIORITY_ADDR) begin
        next_st.rdata = {ipx_pkg::PRIORITY_TOP_READ, st.base_priority_select};
      end else if (sfr_addr_in == ipx_pkg::EXT_PIN_CFG_ADDR) begin
        next_st.rdata = st.ext_pin_irq_config;
      end else if (sfr_addr_in == ipx_pkg::EXT_PRIORITY_ADDR && sfr_prio_bank_in) begin
        next_st.rdata = {ipx_pkg::PRIORITY_TOP_READ, st.extended_irq_priority};
      end else if (sfr_addr_in == ipx_pkg::EXT_ENABLE_ADDR) begin
        next_st.rdata = {ipx_pkg::ENABLE_TOP_READ, st.extended_irq_enable};
      end
    end

    // pins only sampled here; their output path is untouched
    next_st.pin_meta = port0_pin_in;
    next_st.pin_sync = st.pin_meta;

    // the crossbar may not place a peripheral on a skipped pin
    next_st.route = periph_route_in & ~crossbar_skip_reg_in;

    ext_sel_pin[0] = ipx_pick_pin(st.pin_sync, st.ext_pin_irq_config[
      ipx_pkg::EXT0_CHOICE_LSB +: ipx_pkg::CHOICE_WIDTH]);
    ext_sel_pin[1] = ipx_pick_pin(st.pin_sync, st.ext_pin_irq_config[
      ipx_pkg::EXT1_CHOICE_LSB +: ipx_pkg::CHOICE_WIDTH]);
    ext_polarity[0] = st.ext_pin_irq_config[ipx_pkg::EXT0_POLARITY_BIT];
    ext_polarity[1] = st.ext_pin_irq_config[ipx_pkg::EXT1_POLARITY_BIT];

    // polarity 0 means the pin is active low
    ext_active = ~(ext_sel_pin ^ ext_polarity);
    next_st.ext_active_prev = ext_active;

    ext_clear[0] = vector_ack_in && st.valid && (st.source == ipx_pkg::SRC_EXT0);
    ext_clear[1] = vector_ack_in && st.valid && (st.source == ipx_pkg::SRC_EXT1);

    for (int e = 0; e < ipx_pkg::NUM_EXT; e++) begin
      // a new edge in the clearing cycle is kept
      // edges latch only in edge mode, so no stale edge surfaces after a mode switch
      next_st.ext_edge_pending[e] = ext_edge_mode_in[e] &&
                                    ((ext_active[e] && !st.ext_active_prev[e]) ||
                                     (st.ext_edge_pending[e] && !ext_clear[e]));
      ext_flag[e] = ext_edge_mode_in[e] ? next_st.ext_edge_pending[e] : ext_active[e];
    end
    next_st.ext_pending = ext_flag;

    pending = {periph_flag_in[ipx_pkg::PF_CMP_RISE],
               periph_flag_in[ipx_pkg::PF_CMP_FALL],
               periph_flag_in[ipx_pkg::PF_COUNTER],
               periph_flag_in[ipx_pkg::PF_CONV_DONE],
               periph_flag_in[ipx_pkg::PF_WINDOW],
               periph_flag_in[ipx_pkg::PF_TWOWIRE],
               periph_flag_in[ipx_pkg::PF_TMR2],
               periph_flag_in[ipx_pkg::PF_UART],
               periph_flag_in[ipx_pkg::PF_TMR1],
               ext_flag[1],
               periph_flag_in[ipx_pkg::PF_TMR0],
               ext_flag[0]};

    // extended bits 5..0 map onto sources 11..6 in order
    enable = {st.extended_irq_enable, base_enable_in};
    next_st.req = global_irq_gate_in ? (pending & enable) : 12'h000;
    next_st.level = {st.extended_irq_priority, st.base_priority_select};

    // arbitration runs on the registered request set
    hi_mask = st.req & st.level;
    lo_mask = st.req & ~st.level;
    next_st.valid  = 1'b0;
    next_st.source = st.source;
    next_st.high   = st.high;
    if (!st.in_service_high && (hi_mask != 12'h000)) begin
      next_st.valid  = 1'b1;
      next_st.source = ipx_first(hi_mask);
      next_st.high   = 1'b1;
    end else if (!st.in_service_high && !st.in_service_low && (lo_mask != 12'h000)) begin
      next_st.valid  = 1'b1;
      next_st.source = ipx_first(lo_mask);
      next_st.high   = 1'b0;
    end

    // in-service levels: a taken vector blocks equal and lower levels
    if (reti_in) begin
      if (st.in_service_high) begin
        next_st.in_service_high = 1'b0;
      end else begin
        next_st.in_service_low = 1'b0;
      end
    end
    if (vector_ack_in && st.valid) begin
      next_st.valid = 1'b0;
      if (st.high) begin
        next_st.in_service_high = 1'b1;
      end else begin
        next_st.in_service_low = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st                       <= '0;
      st.base_priority_select  <= ipx_pkg::BASE_PRIORITY_RST[5:0];
      st.extended_irq_enable   <= ipx_pkg::EXT_ENABLE_RST[5:0];
      st.extended_irq_priority <= ipx_pkg::EXT_PRIORITY_RST[5:0];
      st.ext_pin_irq_config    <= ipx_pkg::EXT_PIN_CFG_RST;
      // synchronisers reset low; start from the activity low pins give, so no false edge
      st.ext_active_prev       <= ~{ipx_pkg::EXT_PIN_CFG_RST[ipx_pkg::EXT1_POLARITY_BIT],
                                    ipx_pkg::EXT_PIN_CFG_RST[ipx_pkg::EXT0_POLARITY_BIT]};
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata_out    = st.rdata;
  assign periph_route_out = st.route;
  assign irq_req_out      = st.req;
  assign irq_level_out    = st.level;
  assign ext_pending_out  = st.ext_pending;
  assign irq_valid_out    = st.valid;
  assign irq_source_out   = st.source;
  assign irq_high_out     = st.high;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_base_top_ones;
    @(posedge clk_in) disable iff (rst_in)
    (sfr_rd_in && sfr_addr_in == ipx_pkg::BASE_PRIORITY_ADDR) |=> (sfr_rdata_out[7:6] == 2'b11);
  endproperty
  a_base_top_ones: assert property (p_base_top_ones)
    else $error("base priority upper bits not read as ones");

  property p_enable_top_zeros;
    @(posedge clk_in) disable iff (rst_in)
    (sfr_rd_in && sfr_addr_in == ipx_pkg::EXT_ENABLE_ADDR && !sfr_prio_bank_in)
      |=> (sfr_rdata_out[7:6] == 2'b00);
  endproperty
  a_enable_top_zeros: assert property (p_enable_top_zeros)
    else $error("extended enable upper bits not read as zeros");

  property p_prio_top_ones;
    @(posedge clk_in) disable iff (rst_in)
    (sfr_rd_in && sfr_addr_in == ipx_pkg::EXT_PRIORITY_ADDR && sfr_prio_bank_in)
      |=> (sfr_rdata_out[7:6] == 2'b11);
  endproperty
  a_prio_top_ones: assert property (p_prio_top_ones)
    else $error("extended priority upper bits not read as ones");

  property p_gate_off;
    @(posedge clk_in) disable iff (rst_in)
    !global_irq_gate_in |=> (irq_req_out == 12'h000);
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("request forwarded while global gate is off");

  property p_masked_source;
    @(posedge clk_in) disable iff (rst_in)
    (st.extended_irq_enable[3] == 1'b0 && !wr_eie) |=> !irq_req_out[9];
  endproperty
  a_masked_source: assert property (p_masked_source)
    else $error("counter array request passed while masked");

  property p_high_not_preempted;
    @(posedge clk_in) disable iff (rst_in)
    (st.in_service_high && !reti_in) |=> !irq_valid_out;
  endproperty
  a_high_not_preempted: assert property (p_high_not_preempted)
    else $error("new vector offered during high service");

  property p_skip_blocks;
    @(posedge clk_in) disable iff (rst_in)
    1'b1 |=> ((periph_route_out & $past(crossbar_skip_reg_in)) == 8'h00);
  endproperty
  a_skip_blocks: assert property (p_skip_blocks)
    else $error("peripheral routed onto a skipped pin");

  property p_edge_clear;
    @(posedge clk_in) disable iff (rst_in)
    (ext_clear[0] && ext_edge_mode_in[0] && !(ext_active[0] && !st.ext_active_prev[0]))
      |=> !st.ext_edge_pending[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear)
    else $error("edge pending not cleared on vector");

  property p_pin_two_stage;
    @(posedge clk_in) disable iff (rst_in)
    !$past(rst_in, 2) |-> (st.pin_sync == $past(port0_pin_in, 2));
  endproperty
  a_pin_two_stage: assert property (p_pin_two_stage)
    else $error("pin not passed through two sync stages");

  property p_low_not_nested;
    @(posedge clk_in) disable iff (rst_in)
    (st.in_service_low && !reti_in) |=> !(irq_valid_out && !irq_high_out);
  endproperty
  a_low_not_nested: assert property (p_low_not_nested)
    else $error("low vector offered during low service");

  property p_level_follows;
    @(posedge clk_in) disable iff (rst_in)
    !ext_edge_mode_in[1] |=> (ext_pending_out[1] == $past(ext_active[1]));
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("level mode pending does not follow input");

endmodule

// ### ipx_pkg.sv
package ipx_pkg;

  // register bus
  localparam logic [7:0] BASE_PRIORITY_ADDR = 8'hb8;
  localparam logic [7:0] EXT_PIN_CFG_ADDR   = 8'he4;
  localparam logic [7:0] EXT_ENABLE_ADDR    = 8'hf6;
  localparam logic [7:0] EXT_PRIORITY_ADDR  = 8'hf6;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // reset values
  localparam logic [7:0] BASE_PRIORITY_RST  = 8'hc0;
  localparam logic [7:0] EXT_PIN_CFG_RST    = 8'h01;
  localparam logic [7:0] EXT_ENABLE_RST     = 8'h00;
  localparam logic [7:0] EXT_PRIORITY_RST   = 8'hc0;

  // unused upper bits
  localparam int         LIVE_BITS          = 6;
  localparam logic [1:0] PRIORITY_TOP_READ  = 2'h3;
  localparam logic [1:0] ENABLE_TOP_READ    = 2'h0;

  // configuration fields
  localparam int EXT1_POLARITY_BIT = 7;
  localparam int EXT1_CHOICE_LSB   = 4;
  localparam int EXT0_POLARITY_BIT = 3;
  localparam int EXT0_CHOICE_LSB   = 0;
  localparam int CHOICE_WIDTH      = 3;

  // sources, in fixed arbitration order (index 0 wins)
  localparam int NUM_SRC      = 12;
  localparam int SRC_WIDTH    = 4;
  localparam int NUM_PINS     = 8;
  localparam int NUM_EXT      = 2;
  localparam int NUM_PERIPH   = 10;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_EXT1 = 4'h2;

  // peripheral flag positions in the flag port
  localparam int PF_TMR0      = 0;
  localparam int PF_TMR1      = 1;
  localparam int PF_UART      = 2;
  localparam int PF_TMR2      = 3;
  localparam int PF_TWOWIRE   = 4;
  localparam int PF_WINDOW    = 5;
  localparam int PF_CONV_DONE = 6;
  localparam int PF_COUNTER   = 7;
  localparam int PF_CMP_FALL  = 8;
  localparam int PF_CMP_RISE  = 9;

endpackage

// ### ipx_core_model.sv
`timescale 1ns/1ns
// core stand-in: takes an offered vector after a set wait, returns on request
module ipx_core_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // controls from the bench
  input  wire logic       take_en_in,
  input  wire logic [3:0] wait_in,
  input  wire logic       ret_req_in,
  // controller side
  input  wire logic       irq_valid_in,
  output logic            vector_ack_out,
  output logic            reti_out
);
  logic [3:0] cnt;

  always_ff @(posedge clk_in) begin
    vector_ack_out <= 1'b0;
    reti_out       <= ret_req_in & ~rst_in;
    cnt            <= 4'h0;
    // one ack per offer: the offer is still seen in the cycle of the ack
    if (!rst_in && irq_valid_in && take_en_in && !vector_ack_out) begin
      if (cnt == wait_in) vector_ack_out <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule

// ### ipx_irq_ctrl_tb.sv
`timescale 1ns/1ns
module ipx_irq_ctrl_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, bank = 1'b0, gate = 1'b0;
  logic        take = 1'b0, ret_req = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, pins = 8'h00;
  logic [7:0]  skip = 8'h00, route_in = 8'h00;
  logic [5:0]  base_en = 6'h00;
  logic [1:0]  edge_mode = 2'h0;
  logic [9:0]  flags = 10'h000;
  logic [3:0]  wait_cyc = 4'h0;
  logic        ack, reti, valid, high;
  logic [7:0]  rdata, route;
  logic [11:0] req, level;
  logic [1:0]  pend;
  logic [3:0]  src;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #5 clk_in = ~clk_in;

  ipx_irq_ctrl DUT (
    .clk_in(clk_in), .rst_in(rst_in),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_addr_in(addr),
    .sfr_prio_bank_in(bank), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .global_irq_gate_in(gate), .base_enable_in(base_en),
    .ext_edge_mode_in(edge_mode), .periph_flag_in(flags),
    .port0_pin_in(pins), .crossbar_skip_reg_in(skip),
    .periph_route_in(route_in), .periph_route_out(route),
    .vector_ack_in(ack), .reti_in(reti),
    .irq_req_out(req), .irq_level_out(level), .ext_pending_out(pend),
    .irq_valid_out(valid), .irq_source_out(src), .irq_high_out(high)
  );

  ipx_core_model core (
    .clk_in(clk_in), .rst_in(rst_in), .take_en_in(take),
    .wait_in(wait_cyc), .ret_req_in(ret_req), .irq_valid_in(valid),
    .vector_ack_out(ack), .reti_out(reti)
  );

  ////////////////////////////////////////////////////////////
  // drives land by nonblocking assignment at the edge; reads there see last cycle's outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic b, input logic [7:0] d);
    addr  <= a;
    bank  <= b;
    wdata <= d;
    wr    <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic b, input logic [7:0] exp);
    addr <= a;
    bank <= b;
    rd   <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
    chk("read data", {4'h0, exp}, {4'h0, rdata});
  endtask

  task automatic offer(input logic [3:0] s, input logic h);
    for (int i = 0; i < 20 && valid !== 1'b1; i++) cyc(1);
    chk("offer", {6'h00, 1'b1, h, s}, {6'h00, valid, high, src});
  endtask

  task automatic ret();
    ret_req <= 1'b1;
    cyc(1);
    ret_req <= 1'b0;
    cyc(2);
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    rst_in <= 1'b0;
    cyc(1);
    chk("req after reset", 12'h000, req);
    rd_reg(8'hb8, 1'b0, 8'hc0);
    rd_reg(8'he4, 1'b0, 8'h01);
    rd_reg(8'hf6, 1'b0, 8'h00);
    rd_reg(8'hf6, 1'b1, 8'hc0);
    rd_reg(8'h80, 1'b0, 8'h00);
    wr_reg(8'hb8, 1'b0, 8'h15);
    rd_reg(8'hb8, 1'b0, 8'hd5);
    wr_reg(8'hf6, 1'b0, 8'hff);
    rd_reg(8'hf6, 1'b0, 8'h3f);
    wr_reg(8'hf6, 1'b1, 8'h2a);
    rd_reg(8'hf6, 1'b1, 8'hea);
    wr_reg(8'he4, 1'b0, 8'h5a);
    rd_reg(8'he4, 1'b0, 8'h5a);
    chk("levels", 12'ha95, level);
    wr_reg(8'hf6, 1'b1, 8'h00);
    wr_reg(8'hb8, 1'b0, 8'h00);
    // every extended flag up, so a swapped enable bit shows
    gate  <= 1'b1;
    flags <= 10'h3f0;
    for (int i = 0; i < 6; i++) begin
      wr_reg(8'hf6, 1'b0, 8'h01 << i);
      cyc(2);
      chk("one enabled", {6'h01 << i, 6'h00}, req);
      wr_reg(8'hf6, 1'b0, ~(8'h01 << i));
      cyc(2);
      chk("one masked", {~(6'h01 << i), 6'h00}, req);
    end
    gate <= 1'b0;
    cyc(3);
    chk("gate off", 12'h000, req);
    gate    <= 1'b1;
    base_en <= 6'h3f;
    flags   <= 10'h00f;
    wr_reg(8'hf6, 1'b0, 8'h00);
    cyc(2);
    // ext1 sits on low pin 5 with active-low polarity, so it requests too
    chk("base sources", 12'h03e, req);
    flags <= 10'h000;
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'he4, 1'b0, {1'b1, 3'(k), 1'b1, 3'(k)});
      pins <= 8'h01 << k;
      cyc(4);
      chk("pin high active", 12'h003, {10'h000, pend});
      pins <= ~(8'h01 << k);
      cyc(4);
      chk("other pins", 12'h000, {10'h000, pend});
      wr_reg(8'he4, 1'b0, {1'b0, 3'(k), 1'b0, 3'(k)});
      cyc(4);
      chk("pin low active", 12'h003, {10'h000, pend});
    end
    wr_reg(8'he4, 1'b0, 8'ha2);
    pins <= 8'h04;
    cyc(4);
    chk("split polarity", 12'h002, {10'h000, pend});
    route_in <= 8'hff;
    skip     <= 8'h24;
    cyc(2);
    chk("crossbar route", 12'h0db, {4'h0, route});
    // both edge inputs rise together; ext0 wins at equal level
    pins      <= 8'h00;
    edge_mode <= 2'h3;
    wr_reg(8'he4, 1'b0, 8'h98);
    cyc(4);
    pins <= 8'h03;
    offer(4'h0, 1'b0);
    take <= 1'b1;
    cyc(4);
    chk("edge pending after ack", 12'h002, {10'h000, pend});
    chk("no low over low", 12'h000, {11'h000, valid});
    wait_cyc <= 4'h3;
    wr_reg(8'hf6, 1'b1, 8'h08);
    wr_reg(8'hf6, 1'b0, 8'h08);
    flags <= 10'h080;
    offer(4'h9, 1'b1);
    cyc(6);
    flags <= 10'h001;
    wr_reg(8'hb8, 1'b0, 8'h02);
    cyc(4);
    chk("nothing over high", 12'h000, {11'h000, valid});
    ret();
    offer(4'h1, 1'b1);
    cyc(6);
    flags <= 10'h000;
    ret();
    ret();
    offer(4'h2, 1'b0);
    cyc(6);
    chk("ext1 edge cleared", 12'h000, {10'h000, pend});
    conclude();
  end

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
